// ==== hw/cycle_timer_map.vh ====
// Constants of the camera and illumination cycle timer: register map,
// field positions, reset values, mode codes and state codes.
// Assumes inclusion by bare name from the design files of this block.
`ifndef CYCLE_TIMER_MAP_VH
`define CYCLE_TIMER_MAP_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_TRIG_WIDTH 8'h08
`define OFS_LIGHT_WIDTH 8'h0C
`define OFS_LIGHT_OFFSET 8'h10
`define OFS_EXP_GAP 8'h14
`define OFS_MIN_SPACING 8'h18
`define OFS_SEQ_LENGTH 8'h1C
`define OFS_STATUS 8'h20
`define OFS_CYCLE_COUNT 8'h24

// Register indices returned by the address decoder
`define IDX_CTRL 4'h0
`define IDX_CMD 4'h1
`define IDX_TRIG_WIDTH 4'h2
`define IDX_LIGHT_WIDTH 4'h3
`define IDX_LIGHT_OFFSET 4'h4
`define IDX_EXP_GAP 4'h5
`define IDX_MIN_SPACING 4'h6
`define IDX_SEQ_LENGTH 4'h7
`define IDX_STATUS 4'h8
`define IDX_CYCLE_COUNT 4'h9
`define IDX_NONE 4'hF

// Control register fields
`define CTRL_METHOD_LO 0
`define CTRL_METHOD_HI 1
`define CTRL_EARLY 2
`define CTRL_OVERLAP 3
`define CTRL_TRIG_SEL_LO 4
`define CTRL_TRIG_SEL_HI 5
`define CTRL_START_SEL_LO 6
`define CTRL_START_SEL_HI 7
`define CTRL_STOP_SEL_LO 8
`define CTRL_STOP_SEL_HI 9
`define CTRL_W 10

// Command register bits
`define CMD_START_SEQ 0
`define CMD_STOP_SEQ 1
`define CMD_START_CYCLE 2

// Camera control methods
`define METHOD_FREE 2'h0
`define METHOD_EXTERNAL 2'h1
`define METHOD_RATE 2'h2
`define METHOD_RATE_EXP 2'h3

// Source selects
`define SEL_IMMEDIATE 2'h0
`define SEL_COMMAND 2'h1
`define SEL_PIN 2'h2
`define STOP_COMMAND 2'h0
`define STOP_LENGTH 2'h1
`define STOP_PIN 2'h2

// Reset values
`define RST_CTRL 10'h000
`define RST_TRIG_WIDTH 24'h00_0064
`define RST_LIGHT_WIDTH 24'h00_0032
`define RST_LIGHT_OFFSET 24'h00_0004
`define RST_EXP_GAP 24'h00_0010
`define RST_MIN_SPACING 24'h00_03E8
`define RST_SEQ_LENGTH 24'h00_0001

// Widths and slack
`define TW 24
`define CW 26
`define PERMIT_SLACK 26'h000_0003

// Sequence states
`define SEQ_IDLE 1'b0
`define SEQ_RUN 1'b1

`endif

// ==== hw/sync_bus.v ====
// Two-flip-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are slow levels from pins outside the pclk domain.
`default_nettype none

module sync_bus #(
  parameter W = 3
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

reg [W-1:0] meta_r;
reg [W-1:0] stable_r;

genvar i;
generate
  for (i = 0; i < W; i = i + 1)
  begin : g_bit
    always @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        meta_r[i] <= 1'b0;
        stable_r[i] <= 1'b0;
      end
      else
      begin
        meta_r[i] <= async_in[i];
        stable_r[i] <= meta_r[i];
      end
    end
  end
endgenerate

assign sync_out = stable_r;

endmodule // sync_bus

`default_nettype wire

// ==== hw/pulse_shaper.v ====
// One delayed pulse per start: high from count delay for width counts.
// Assumes start is a one-cycle pulse on pclk; abort drops the output.
`default_nettype none
`include "cycle_timer_map.vh"

module pulse_shaper (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire abort,
  input wire [`TW-1:0] delay,
  input wire [`TW-1:0] width,
  output reg pulse_r
);

reg act_r;
reg [`TW:0] cnt_r;
wire [`TW-1:0] eff_width;
wire [`TW:0] end_cnt;

// A zero width still yields a single one-clock pulse
assign eff_width = (width == {`TW{1'b0}}) ? {{(`TW-1){1'b0}}, 1'b1} : width;
assign end_cnt = {1'b0, delay} + {1'b0, eff_width};

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    act_r <= 1'b0;
    cnt_r <= {(`TW+1){1'b0}};
    pulse_r <= 1'b0;
  end
  else if (abort)
  begin
    act_r <= 1'b0;
    cnt_r <= {(`TW+1){1'b0}};
    pulse_r <= 1'b0;
  end
  else if (start)
  begin
    act_r <= 1'b1;
    cnt_r <= {(`TW+1){1'b0}};
    pulse_r <= (delay == {`TW{1'b0}});
  end
  else if (act_r)
  begin
    cnt_r <= cnt_r + {{`TW{1'b0}}, 1'b1};
    pulse_r <= ((cnt_r + {{`TW{1'b0}}, 1'b1}) >= {1'b0, delay}) &&
               ((cnt_r + {{`TW{1'b0}}, 1'b1}) < end_cnt);
    if ((cnt_r + {{`TW{1'b0}}, 1'b1}) >= end_cnt)
    begin
      act_r <= 1'b0;
    end
  end
end

endmodule // pulse_shaper

`default_nettype wire

// ==== hw/camera_illumination_cycle_timer.v ====
// Camera and illumination cycle timer with APB register access.
// Assumes an APB master on pclk, pins needing synchronisation, and
// mem_space_ok from same-clock acquisition logic.
`default_nettype none
`include "cycle_timer_map.vh"

// Function
// - Four camera control methods selectable
// - Passive methods: no trigger, no light pulse
// - Rate-only: one trigger per cycle, leading edge
// - Rate-exposure: trailing edge ends exposure
// - One camera trigger, one light output
// - Each start: one trigger, light, permit
// - Trigger width equals programmed exposure
// - Light width equals programmed duration
// - Light offset between trigger and light leading edges
// - Late arrangement: light after trigger edge
// - Early arrangement: trigger after light edge
// - No new cycle before permit
// - Hold start while any condition unmet
// - Overlap places permit earlier
// - Overlap respects inter-exposure gap
// - Starts never closer than minimum spacing
// - Sequences bounded by start, stop conditions
// - Immediate source: self-trigger after each permit
module camera_illumination_cycle_timer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire cycle_trigger_pin,
  input wire seq_start_pin,
  input wire seq_stop_pin,
  input wire mem_space_ok,
  output wire trigger_out,
  output wire light_out,
  output reg cycle_begin_event_r,
  output reg next_cycle_permit_r
);

////////////////////////////////////////////////////////////////////////
// Register decode

function [3:0] reg_index;
  input [31:0] addr;
  begin
    if (addr[31:8] != 24'h00_0000 || addr[1:0] != 2'h0)
      reg_index = `IDX_NONE;
    else if (addr[7:0] == `OFS_CTRL)
      reg_index = `IDX_CTRL;
    else if (addr[7:0] == `OFS_CMD)
      reg_index = `IDX_CMD;
    else if (addr[7:0] == `OFS_TRIG_WIDTH)
      reg_index = `IDX_TRIG_WIDTH;
    else if (addr[7:0] == `OFS_LIGHT_WIDTH)
      reg_index = `IDX_LIGHT_WIDTH;
    else if (addr[7:0] == `OFS_LIGHT_OFFSET)
      reg_index = `IDX_LIGHT_OFFSET;
    else if (addr[7:0] == `OFS_EXP_GAP)
      reg_index = `IDX_EXP_GAP;
    else if (addr[7:0] == `OFS_MIN_SPACING)
      reg_index = `IDX_MIN_SPACING;
    else if (addr[7:0] == `OFS_SEQ_LENGTH)
      reg_index = `IDX_SEQ_LENGTH;
    else if (addr[7:0] == `OFS_STATUS)
      reg_index = `IDX_STATUS;
    else if (addr[7:0] == `OFS_CYCLE_COUNT)
      reg_index = `IDX_CYCLE_COUNT;
    else
      reg_index = `IDX_NONE;
  end
endfunction

function [`CW-1:0] max_cw;
  input [`CW-1:0] a;
  input [`CW-1:0] b;
  begin
    max_cw = (a > b) ? a : b;
  end
endfunction

reg [`CTRL_W-1:0] ctrl_r;
reg [`TW-1:0] trig_width_r;
reg [`TW-1:0] light_width_r;
reg [`TW-1:0] light_offset_r;
reg [`TW-1:0] exp_gap_r;
reg [`TW-1:0] min_spacing_r;
reg [`TW-1:0] seq_length_r;
reg [`TW-1:0] done_cnt_r;
reg seq_state_r;
reg start_armed_r;
reg stop_pend_r;
reg trig_pend_r;
reg busy_r;
reg [`CW-1:0] cyc_cnt_r;
reg [`CW-1:0] permit_at_r;
reg [`CW-1:0] permit_at_nxt;
reg [2:0] pin_prev_r;

wire [3:0] idx;
wire wr_en;
wire rd_setup;
wire [2:0] pins_sync;
wire [2:0] pin_rise;
wire [1:0] method;
wire [1:0] trig_sel;
wire [1:0] start_sel;
wire [1:0] stop_sel;
wire method_active;
wire cmd_start_seq;
wire cmd_stop_seq;
wire cmd_start_cycle;
wire start_req;
wire stop_req;
wire cycle_req;
wire len_reached;
wire seq_end;
wire go;
wire [`TW-1:0] trig_delay;
wire [`TW-1:0] light_delay;
wire [`CW-1:0] exp_end;
wire [`CW-1:0] light_end;
wire [`CW-1:0] spacing;

assign idx = reg_index(paddr);
assign wr_en = psel && penable && pwrite;
assign rd_setup = psel && !penable && !pwrite;
assign pready = 1'b1;
assign pslverr = psel && penable && (idx == `IDX_NONE);

////////////////////////////////////////////////////////////////////////
// Pin synchronisation and edges

sync_bus #(
  .W(3)
) u_sync (
  .pclk(pclk),
  .presetn(presetn),
  .async_in({seq_stop_pin, seq_start_pin, cycle_trigger_pin}),
  .sync_out(pins_sync)
);

assign pin_rise = pins_sync & ~pin_prev_r;

////////////////////////////////////////////////////////////////////////
// Mode and request decode

assign method = ctrl_r[`CTRL_METHOD_HI:`CTRL_METHOD_LO];
assign trig_sel = ctrl_r[`CTRL_TRIG_SEL_HI:`CTRL_TRIG_SEL_LO];
assign start_sel = ctrl_r[`CTRL_START_SEL_HI:`CTRL_START_SEL_LO];
assign stop_sel = ctrl_r[`CTRL_STOP_SEL_HI:`CTRL_STOP_SEL_LO];
// Free-run and external methods leave the cycle machinery idle
assign method_active = (method == `METHOD_RATE) ||
                       (method == `METHOD_RATE_EXP);

assign cmd_start_seq = wr_en && (idx == `IDX_CMD) && pwdata[`CMD_START_SEQ];
assign cmd_stop_seq = wr_en && (idx == `IDX_CMD) && pwdata[`CMD_STOP_SEQ];
assign cmd_start_cycle = wr_en && (idx == `IDX_CMD) &&
                         pwdata[`CMD_START_CYCLE];

assign start_req = cmd_start_seq ||
                   ((start_sel == `SEL_IMMEDIATE) && start_armed_r) ||
                   ((start_sel == `SEL_PIN) && pin_rise[1]);
assign stop_req = cmd_stop_seq ||
                  ((stop_sel == `STOP_PIN) && pin_rise[2]);
assign cycle_req = cmd_start_cycle ||
                   ((trig_sel == `SEL_PIN) && pin_rise[0]);
assign len_reached = (stop_sel == `STOP_LENGTH) &&
                     (done_cnt_r >= seq_length_r);
// Sequence ends only at a cycle boundary
assign seq_end = !busy_r && !cycle_begin_event_r &&
                 (stop_pend_r || len_reached || !method_active);

assign go = method_active && (seq_state_r == `SEQ_RUN) && !seq_end &&
            !busy_r && !cycle_begin_event_r && mem_space_ok &&
            ((trig_sel == `SEL_IMMEDIATE) || trig_pend_r);

////////////////////////////////////////////////////////////////////////
// Intra-cycle placement

// Late arrangement delays the light; early arrangement the trigger
assign trig_delay = ctrl_r[`CTRL_EARLY] ? light_offset_r :
                    {`TW{1'b0}};
assign light_delay = ctrl_r[`CTRL_EARLY] ? {`TW{1'b0}} :
                     light_offset_r;
assign exp_end = {2'b00, trig_delay} + {2'b00, trig_width_r};
assign light_end = {2'b00, light_delay} + {2'b00, light_width_r};
assign spacing = {2'b00, min_spacing_r};

// Permit time from cycle start, in clocks
always @*
begin
  if (ctrl_r[`CTRL_OVERLAP])
    permit_at_nxt = max_cw(spacing,
                           exp_end + {2'b00, exp_gap_r});
  else
    permit_at_nxt = exp_end + spacing;
  permit_at_nxt = max_cw(permit_at_nxt, max_cw(exp_end, light_end)) +
                  `PERMIT_SLACK;
end

pulse_shaper u_trigger (
  .pclk(pclk),
  .presetn(presetn),
  .start(cycle_begin_event_r),
  .abort(!method_active),
  .delay(trig_delay),
  .width(trig_width_r),
  .pulse_r(trigger_out)
);

pulse_shaper u_light (
  .pclk(pclk),
  .presetn(presetn),
  .start(cycle_begin_event_r),
  .abort(!method_active),
  .delay(light_delay),
  .width(light_width_r),
  .pulse_r(light_out)
);

////////////////////////////////////////////////////////////////////////
// Registers, sequence and cycle control

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    ctrl_r <= `RST_CTRL;
    trig_width_r <= `RST_TRIG_WIDTH;
    light_width_r <= `RST_LIGHT_WIDTH;
    light_offset_r <= `RST_LIGHT_OFFSET;
    exp_gap_r <= `RST_EXP_GAP;
    min_spacing_r <= `RST_MIN_SPACING;
    seq_length_r <= `RST_SEQ_LENGTH;
    pin_prev_r <= 3'h0;
    seq_state_r <= `SEQ_IDLE;
    start_armed_r <= 1'b1;
    stop_pend_r <= 1'b0;
    trig_pend_r <= 1'b0;
    busy_r <= 1'b0;
    cyc_cnt_r <= {`CW{1'b0}};
    permit_at_r <= {`CW{1'b0}};
    done_cnt_r <= {`TW{1'b0}};
    cycle_begin_event_r <= 1'b0;
    next_cycle_permit_r <= 1'b0;
  end
  else
  begin
    pin_prev_r <= pins_sync;
    if (wr_en && idx == `IDX_CTRL)
      ctrl_r <= pwdata[`CTRL_W-1:0];
    if (wr_en && idx == `IDX_TRIG_WIDTH)
      trig_width_r <= pwdata[`TW-1:0];
    if (wr_en && idx == `IDX_LIGHT_WIDTH)
      light_width_r <= pwdata[`TW-1:0];
    if (wr_en && idx == `IDX_LIGHT_OFFSET)
      light_offset_r <= pwdata[`TW-1:0];
    if (wr_en && idx == `IDX_EXP_GAP)
      exp_gap_r <= pwdata[`TW-1:0];
    if (wr_en && idx == `IDX_MIN_SPACING)
      min_spacing_r <= pwdata[`TW-1:0];
    if (wr_en && idx == `IDX_SEQ_LENGTH)
      seq_length_r <= pwdata[`TW-1:0];

    cycle_begin_event_r <= go;
    case (seq_state_r)
      `SEQ_IDLE:
      begin
        stop_pend_r <= 1'b0;
        trig_pend_r <= 1'b0;
        // Writing control re-arms an immediate start
        if (wr_en && idx == `IDX_CTRL)
          start_armed_r <= 1'b1;
        else if (method_active && start_req)
        begin
          start_armed_r <= 1'b0;
          seq_state_r <= `SEQ_RUN;
          done_cnt_r <= {`TW{1'b0}};
        end
      end
      default:
      begin
        if (seq_end)
          seq_state_r <= `SEQ_IDLE;
        if (stop_req)
          stop_pend_r <= 1'b1;
        // A new request in the start cycle wins over the clear
        if (cycle_req)
          trig_pend_r <= 1'b1;
        else if (go)
          trig_pend_r <= 1'b0;
        if (cycle_begin_event_r)
          done_cnt_r <= done_cnt_r + {{(`TW-1){1'b0}}, 1'b1};
      end
    endcase

    next_cycle_permit_r <= 1'b0;
    if (go)
    begin
      busy_r <= 1'b1;
      cyc_cnt_r <= {`CW{1'b0}};
      permit_at_r <= permit_at_nxt;
    end
    else if (busy_r)
    begin
      cyc_cnt_r <= cyc_cnt_r + {{(`CW-1){1'b0}}, 1'b1};
      if (cyc_cnt_r == permit_at_r)
      begin
        busy_r <= 1'b0;
        next_cycle_permit_r <= 1'b1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Read data, captured in the setup phase

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    prdata <= 32'h0000_0000;
  else if (rd_setup)
  begin
    if (idx == `IDX_CTRL)
      prdata <= {{(32-`CTRL_W){1'b0}}, ctrl_r};
    else if (idx == `IDX_TRIG_WIDTH)
      prdata <= {8'h00, trig_width_r};
    else if (idx == `IDX_LIGHT_WIDTH)
      prdata <= {8'h00, light_width_r};
    else if (idx == `IDX_LIGHT_OFFSET)
      prdata <= {8'h00, light_offset_r};
    else if (idx == `IDX_EXP_GAP)
      prdata <= {8'h00, exp_gap_r};
    else if (idx == `IDX_MIN_SPACING)
      prdata <= {8'h00, min_spacing_r};
    else if (idx == `IDX_SEQ_LENGTH)
      prdata <= {8'h00, seq_length_r};
    else if (idx == `IDX_STATUS)
      prdata <= {26'h000_0000, stop_pend_r, trig_pend_r, light_out,
                 trigger_out, busy_r, seq_state_r};
    else if (idx == `IDX_CYCLE_COUNT)
      prdata <= {8'h00, done_cnt_r};
    else
      prdata <= 32'h0000_0000;
  end
end

endmodule // camera_illumination_cycle_timer

`default_nettype wire

// ==== bench/timer_props.sv ====
// Port checker of the cycle timer, bound to the top module below.
// Assumes zero-wait APB writes and timing counted in pclk edges.
`default_nettype none
`include "cycle_timer_map.vh"

module timer_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic cycle_trigger_pin,
  input wire logic seq_start_pin,
  input wire logic seq_stop_pin,
  input wire logic mem_space_ok,
  input wire logic trigger_out,
  input wire logic light_out,
  input wire logic cycle_begin_event_r,
  input wire logic next_cycle_permit_r
);
  logic wr_take, early_r, open_r;
  logic [1:0] method_r, quiet_r;
  logic [23:0] tw_r, lw_r, sp_r, since_r, th_r, lh_r;
  assign wr_take = psel && penable && pwrite && pready;
  // Mirror of programmed settings, spacing and pulse-length counters
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {method_r, early_r, open_r, quiet_r} <= 6'h00;
      tw_r <= `RST_TRIG_WIDTH;
      lw_r <= `RST_LIGHT_WIDTH;
      sp_r <= `RST_MIN_SPACING;
      since_r <= 24'hFF_FFFF;
      th_r <= 24'h00_0000;
      lh_r <= 24'h00_0000;
    end
    else
    begin
      if (wr_take && paddr == `OFS_CTRL)
        {early_r, method_r} <= pwdata[2:0];
      if (wr_take && paddr == `OFS_TRIG_WIDTH)
        tw_r <= pwdata[23:0];
      if (wr_take && paddr == `OFS_LIGHT_WIDTH)
        lw_r <= pwdata[23:0];
      if (wr_take && paddr == `OFS_MIN_SPACING)
        sp_r <= pwdata[23:0];
      if (cycle_begin_event_r)
        since_r <= 24'h00_0001;
      else if (since_r != 24'hFF_FFFF)
        since_r <= since_r + 24'h00_0001;
      if (cycle_begin_event_r)
        open_r <= 1'b1;
      else if (next_cycle_permit_r)
        open_r <= 1'b0;
      if (method_r >= `METHOD_RATE)
        quiet_r <= 2'h0;
      else if (quiet_r != 2'h3)
        quiet_r <= quiet_r + 2'h1;
      th_r <= trigger_out ? th_r + 24'h00_0001 : 24'h00_0000;
      lh_r <= light_out ? lh_r + 24'h00_0001 : 24'h00_0000;
    end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  begin_pulse_a: assert property (
    cycle_begin_event_r |=> !cycle_begin_event_r)
    else $error("Begin pulse longer than one clock");
  permit_pulse_a: assert property (
    next_cycle_permit_r |=> !next_cycle_permit_r)
    else $error("Permit pulse longer than one clock");
  permit_first_a: assert property (
    cycle_begin_event_r |-> !open_r)
    else $error("Cycle began before permit of previous cycle");
  spacing_min_a: assert property (
    cycle_begin_event_r |-> since_r >= sp_r)
    else $error("Cycle starts closer than minimum spacing");
  passive_quiet_a: assert property (
    quiet_r == 2'h3 |-> !trigger_out && !light_out && !cycle_begin_event_r)
    else $error("Activity under a passive method");
  trig_width_a: assert property (
    $fell(trigger_out) && method_r >= `METHOD_RATE
      |-> th_r == (tw_r == 24'h00_0000 ? 24'h00_0001 : tw_r))
    else $error("Trigger width differs from setting");
  light_width_a: assert property (
    $fell(light_out) && method_r >= `METHOD_RATE
      |-> lh_r == (lw_r == 24'h00_0000 ? 24'h00_0001 : lw_r))
    else $error("Light width differs from setting");
  late_trig_a: assert property (
    cycle_begin_event_r && !early_r |=> $rose(trigger_out))
    else $error("Trigger did not lead in late arrangement");
  early_light_a: assert property (
    cycle_begin_event_r && early_r |=> $rose(light_out))
    else $error("Light did not lead in early arrangement");
  err_phase_a: assert property (
    pslverr |-> psel && penable)
    else $error("Slave error outside access phase");
endmodule // timer_props

bind camera_illumination_cycle_timer timer_props u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .cycle_trigger_pin, .seq_start_pin, .seq_stop_pin, .mem_space_ok,
  .trigger_out, .light_out, .cycle_begin_event_r, .next_cycle_permit_r);
`default_nettype wire

// ==== bench/cam_light_model.sv ====
// Camera and switched light source on the trigger and light pins.
// Assumes pins launched from pclk flops; times counted in pclk edges.
`default_nettype none

module cam_light_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trigger_out,
  input wire logic light_out,
  input wire logic cycle_begin_event_r,
  input wire logic next_cycle_permit_r,
  output logic [15:0] n_begin,
  output logic [15:0] n_trig,
  output logic [15:0] n_light,
  output logic [15:0] trig_lead,
  output logic [15:0] light_lead,
  output logic [15:0] trig_len,
  output logic [15:0] light_len,
  output logic [15:0] permit_at,
  output logic [15:0] spacing
);
  logic [15:0] t;
  logic tq, lq;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {n_begin, n_trig, n_light, trig_lead, light_lead, t} <= '0;
      {trig_len, light_len, permit_at, spacing, tq, lq} <= '0;
    end
    else
    begin
      tq <= trigger_out;
      lq <= light_out;
      t <= cycle_begin_event_r ? 16'h0001 : t + 16'h0001;
      if (cycle_begin_event_r)
      begin
        n_begin <= n_begin + 16'h0001;
        spacing <= t;
      end
      // Exposure opens on the leading edge; length ends it if controlled
      if (trigger_out && !tq)
      begin
        n_trig <= n_trig + 16'h0001;
        trig_lead <= t;
        trig_len <= 16'h0001;
      end
      else if (trigger_out)
        trig_len <= trig_len + 16'h0001;
      // Light on at the leading edge, off at the falling edge
      if (light_out && !lq)
      begin
        n_light <= n_light + 16'h0001;
        light_lead <= t;
        light_len <= 16'h0001;
      end
      else if (light_out)
        light_len <= light_len + 16'h0001;
      if (next_cycle_permit_r)
        permit_at <= t;
    end
endmodule // cam_light_model
`default_nettype wire

// ==== bench/camera_illumination_cycle_timer_bench.sv ====
// Self-checking bench of the camera and illumination cycle timer.
// Assumes the far-side model and the bound port checker are compiled.
`default_nettype none
`include "cycle_timer_map.vh"

module camera_illumination_cycle_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, q;
  logic cycle_trigger_pin, seq_start_pin, seq_stop_pin, mem_space_ok;
  logic trigger_out, light_out, cycle_begin_event_r, next_cycle_permit_r;
  logic [15:0] n_begin, n_trig, n_light, trig_lead, light_lead, b0, t0, l0;
  logic [15:0] trig_len, light_len, permit_at, spacing;
  logic e;
  int n_mismatch, comparisons, cycles;

  camera_illumination_cycle_timer DUT (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .cycle_trigger_pin, .seq_start_pin, .seq_stop_pin, .mem_space_ok,
    .trigger_out, .light_out, .cycle_begin_event_r, .next_cycle_permit_r);
  cam_light_model far_side (.pclk, .presetn, .trigger_out, .light_out,
    .cycle_begin_event_r, .next_cycle_permit_r, .n_begin, .n_trig,
    .n_light, .trig_lead, .light_lead, .trig_len, .light_len, .permit_at,
    .spacing);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task results;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  function logic [31:0] ctl(input logic [1:0] m, input logic ea, ov,
    input logic [1:0] ts, ss, st);
    return {22'h0, st, ss, ts, ov, ea, m};
  endfunction

  task upto(input logic [15:0] n);
    for (int k = 0; k < 3000 && n_begin !== n; k++)
      @(posedge pclk);
  endtask

  task snap;
    b0 = n_begin;
    t0 = n_trig;
    l0 = n_light;
  endtask

  task halt;
    wr(`OFS_CMD, 32'h0000_0002);
    repeat (150) @(posedge pclk);
    chk("trigger count", n_begin - b0, n_trig - t0);
    chk("light count", n_begin - b0, n_light - l0);
    b0 = n_begin;
    repeat (100) @(posedge pclk);
    chk("begins after stop", b0, n_begin);
    wr(`OFS_CTRL, 32'h0000_0000);
  endtask

  task t_reset;
    logic [31:0] a [7];
    logic [31:0] v [7];
    a = '{`OFS_CTRL, `OFS_TRIG_WIDTH, `OFS_LIGHT_WIDTH, `OFS_LIGHT_OFFSET,
      `OFS_EXP_GAP, `OFS_MIN_SPACING, `OFS_SEQ_LENGTH};
    v = '{`RST_CTRL, `RST_TRIG_WIDTH, `RST_LIGHT_WIDTH, `RST_LIGHT_OFFSET,
      `RST_EXP_GAP, `RST_MIN_SPACING, `RST_SEQ_LENGTH};
    chk("trigger at reset", 0, trigger_out);
    chk("light at reset", 0, light_out);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, a[i], 32'h0000_0000);
      chk("reset value", v[i], q);
    end
    apb(1'b0, 32'h0000_0028, 32'h0000_0000);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, q);
    apb(1'b0, 32'h0000_0009, 32'h0000_0000);
    chk("misaligned error", 1, e);
  endtask

  task t_passive;
    for (int m = 0; m < 2; m++)
    begin
      wr(`OFS_CTRL, ctl(m, 0, 0, 0, 0, 0));
      apb(1'b0, `OFS_CTRL, 32'h0000_0000);
      chk("method", m, q);
      repeat (80) @(posedge pclk);
      chk("passive begins", 0, n_begin);
      chk("passive pulses", 0, n_trig | n_light);
    end
  endtask

  task t_rate_late;
    wr(`OFS_TRIG_WIDTH, 32'h0000_0005);
    wr(`OFS_LIGHT_WIDTH, 32'h0000_0003);
    wr(`OFS_LIGHT_OFFSET, 32'h0000_0002);
    wr(`OFS_MIN_SPACING, 32'h0000_0028);
    snap();
    wr(`OFS_CTRL, ctl(`METHOD_RATE, 0, 0, 0, 0, `STOP_COMMAND));
    upto(b0 + 16'h0002);
    repeat (10) @(posedge pclk);
    chk("trigger lead", 1, trig_lead);
    chk("light lead", 3, light_lead);
    chk("trigger width", 5, trig_len);
    chk("light width", 3, light_len);
    chk("permit time", 49, permit_at);
    chk("spacing", 1, spacing >= 50 && spacing <= 52);
    halt();
  endtask

  task t_exp_early;
    wr(`OFS_TRIG_WIDTH, 32'h0000_0014);
    wr(`OFS_LIGHT_WIDTH, 32'h0000_0004);
    wr(`OFS_LIGHT_OFFSET, 32'h0000_0003);
    wr(`OFS_EXP_GAP, 32'h0000_0006);
    wr(`OFS_MIN_SPACING, 32'h0000_000A);
    snap();
    wr(`OFS_CTRL, ctl(`METHOD_RATE_EXP, 1, 1, 0, 0, `STOP_COMMAND));
    upto(b0 + 16'h0002);
    repeat (30) @(posedge pclk);
    chk("light lead", 1, light_lead);
    chk("trigger lead", 4, trig_lead);
    chk("exposure width", 20, trig_len);
    chk("light width", 4, light_len);
    chk("overlap permit", 33, permit_at);
    chk("spacing", 1, spacing >= 34 && spacing <= 36);
    halt();
  endtask

  task t_seq_len;
    wr(`OFS_SEQ_LENGTH, 32'h0000_0003);
    snap();
    wr(`OFS_CTRL, ctl(`METHOD_RATE, 0, 0, 0, 0, `STOP_LENGTH));
    repeat (300) @(posedge pclk);
    chk("length begins", b0 + 16'h0003, n_begin);
    chk("length triggers", t0 + 16'h0003, n_trig);
    apb(1'b0, `OFS_CYCLE_COUNT, 32'h0000_0000);
    chk("cycle count", 3, q);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("sequence running", 0, q[0]);
    wr(`OFS_CTRL, 32'h0000_0000);
  endtask

  task t_cmd;
    snap();
    wr(`OFS_CTRL, ctl(`METHOD_RATE, 0, 0, `SEL_COMMAND, `SEL_COMMAND, 0));
    repeat (50) @(posedge pclk);
    chk("before sequence", b0, n_begin);
    wr(`OFS_CMD, 32'h0000_0001);
    repeat (50) @(posedge pclk);
    chk("without trigger", b0, n_begin);
    mem_space_ok <= 1'b0;
    wr(`OFS_CMD, 32'h0000_0004);
    repeat (50) @(posedge pclk);
    chk("memory short", b0, n_begin);
    mem_space_ok <= 1'b1;
    upto(b0 + 16'h0001);
    chk("command cycle", b0 + 16'h0001, n_begin);
    wr(`OFS_CTRL, ctl(`METHOD_RATE, 0, 0, `SEL_PIN, `SEL_PIN, `STOP_PIN));
    repeat (60) @(posedge pclk);
    cycle_trigger_pin <= 1'b1;
    upto(b0 + 16'h0002);
    chk("pin cycle", b0 + 16'h0002, n_begin);
    cycle_trigger_pin <= 1'b0;
    seq_stop_pin <= 1'b1;
    repeat (60) @(posedge pclk);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("pin stop", 0, q[0]);
    seq_start_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("pin start", 1, q[0]);
    halt();
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cycle_trigger_pin, seq_start_pin, seq_stop_pin} = 3'h0;
    mem_space_ok = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_passive();
    t_rate_late();
    t_exp_early();
    t_seq_len();
    t_cmd();
    results();
  end
endmodule // camera_illumination_cycle_timer_bench
`default_nettype wire
